/* File: gsc_alias_top.sv */
// APB slave holding the pin output value register with its set and clear aliases.
`timescale 1ns/1ns
module gsc_alias_top #(
	parameter int unsigned AW = gsc_pkg::ADDR_W
) (
	// Clock and reset.
	input  wire logic          pclk,
	input  wire logic          presetn,
	// APB slave.
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	// Video control pins.
	output logic               video_ctrl_pin_one,
	output logic               video_ctrl_pin_one_oe,
	input  wire logic          video_ctrl_pin_one_in,
	output logic               video_ctrl_pin_two,
	output logic               video_ctrl_pin_two_oe,
	input  wire logic          video_ctrl_pin_two_in,
	output logic               video_ctrl_pin_three,
	output logic               video_ctrl_pin_three_oe,
	input  wire logic          video_ctrl_pin_three_in,
	// Video pixel pins, bits 19 down to 2.
	output logic      [19:2]   video_pixel_pins,
	output logic      [19:2]   video_pixel_pins_oe,
	input  wire logic [19:2]   video_pixel_pins_in
);

	localparam int unsigned PW = gsc_pkg::PIN_W;

	gsc_pkg::gsc_phase_e phase;
	gsc_pkg::gsc_phase_e next_phase;
	logic [PW-1:0]       pin_output_value_reg;
	logic [PW-1:0]       next_value;
	logic [PW-1:0]       pin_dir;
	logic [PW-1:0]       next_dir;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;
	logic [PW-1:0]       pin_level;
	logic [PW-1:0]       pin_out;
	logic [PW-1:0]       pin_oe;
	logic [PW-1:0]       pin_in;
	logic [PW-1:0]       wr_bits;
	logic                addr_hit;
	logic                wr_done;

	// Byte enables widened to a bit mask, trimmed to the implemented pin field.
	function automatic logic [PW-1:0] pin_field(input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] word;
		word = data & gsc_pkg::PIN_MASK;
		for (int i = 0; i < 4; i++) begin
			if (!strb[i]) begin
				word[i*8 +: 8] = 8'h00;
			end
		end
		return word[gsc_pkg::PIN_HI:gsc_pkg::PIN_LO];
	endfunction : pin_field

	// Places a pin field back into a bus word with reserved bits at zero.
	function automatic logic [31:0] pin_word(input logic [PW-1:0] field);
		logic [31:0] word;
		word = gsc_pkg::WORD_ZERO;
		word[gsc_pkg::PIN_HI:gsc_pkg::PIN_LO] = field;
		return word;
	endfunction : pin_word

	always_comb begin
		addr_hit = (paddr == gsc_pkg::OFF_VALUE) || (paddr == gsc_pkg::OFF_SET) ||
			(paddr == gsc_pkg::OFF_CLEAR) || (paddr == gsc_pkg::OFF_DIR) ||
			(paddr == gsc_pkg::OFF_LEVEL);
		wr_done  = (phase == gsc_pkg::GSC_ACCESS) && psel && penable && pready && pwrite;
		wr_bits  = pin_field(pwdata, pstrb);
	end

	// Bus phase, read data and register updates.
	always_comb begin
		next_phase   = phase;
		next_prdata  = gsc_pkg::WORD_ZERO;
		next_pready  = 1'b0;
		next_pslverr = 1'b0;
		next_value   = pin_output_value_reg;
		next_dir     = pin_dir;
		case (phase)
			gsc_pkg::GSC_IDLE: begin
				if (psel && !penable) begin
					next_phase   = gsc_pkg::GSC_ACCESS;
					next_pready  = 1'b1;
					next_pslverr = !addr_hit;
					if (!pwrite) begin
						case (paddr)
							gsc_pkg::OFF_VALUE: begin
								next_prdata = pin_word(pin_output_value_reg);
							end
							gsc_pkg::OFF_DIR: begin
								next_prdata = pin_word(pin_dir);
							end
							gsc_pkg::OFF_LEVEL: begin
								next_prdata = pin_word(pin_level);
							end
							default: begin
								next_prdata = gsc_pkg::WORD_ZERO;
							end
						endcase
					end
				end
			end
			gsc_pkg::GSC_ACCESS: begin
				next_phase = gsc_pkg::GSC_IDLE;
				if (wr_done) begin
					case (paddr)
						gsc_pkg::OFF_VALUE: begin
							// Only the enabled byte lanes are replaced; the rest keep their value.
							next_value = (pin_output_value_reg & ~pin_field(32'hFFFF_FFFF, pstrb)) |
								wr_bits;
						end
						gsc_pkg::OFF_SET: begin
							next_value = pin_output_value_reg | wr_bits;
						end
						gsc_pkg::OFF_CLEAR: begin
							next_value = pin_output_value_reg & ~wr_bits;
						end
						gsc_pkg::OFF_DIR: begin
							next_dir = (pin_dir & ~pin_field(32'hFFFF_FFFF, pstrb)) | wr_bits;
						end
						default: begin
							next_value = pin_output_value_reg;
						end
					endcase
				end
			end
			default: begin
				next_phase = gsc_pkg::GSC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase                <= gsc_pkg::GSC_IDLE;
			prdata               <= gsc_pkg::WORD_ZERO;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			pin_output_value_reg <= gsc_pkg::PIN_RST;
			pin_dir              <= gsc_pkg::PIN_RST;
		end else begin
			phase                <= next_phase;
			prdata               <= next_prdata;
			pready               <= next_pready;
			pslverr              <= next_pslverr;
			pin_output_value_reg <= next_value;
			pin_dir              <= next_dir;
		end
	end

	// Field bit n sits at word bit n + 2, so the pixel slice keeps its own index.
	always_comb begin
		pin_in = {video_ctrl_pin_three_in, video_ctrl_pin_two_in, video_ctrl_pin_one_in,
			video_pixel_pins_in};
	end

	gsc_pin_drive #(
		.WIDTH (PW)
	) u_pin_drive (
		.pclk    (pclk),
		.presetn (presetn),
		.value   (pin_output_value_reg),
		.dir_out (pin_dir),
		.level   (pin_level),
		.pin_out (pin_out),
		.pin_oe  (pin_oe),
		.pin_in  (pin_in)
	);

	always_comb begin
		video_ctrl_pin_three    = pin_out[gsc_pkg::CTRL_THREE - gsc_pkg::PIN_LO];
		video_ctrl_pin_three_oe = pin_oe[gsc_pkg::CTRL_THREE - gsc_pkg::PIN_LO];
		video_ctrl_pin_two      = pin_out[gsc_pkg::CTRL_TWO - gsc_pkg::PIN_LO];
		video_ctrl_pin_two_oe   = pin_oe[gsc_pkg::CTRL_TWO - gsc_pkg::PIN_LO];
		video_ctrl_pin_one      = pin_out[gsc_pkg::CTRL_ONE - gsc_pkg::PIN_LO];
		video_ctrl_pin_one_oe   = pin_oe[gsc_pkg::CTRL_ONE - gsc_pkg::PIN_LO];
		video_pixel_pins        = pin_out[gsc_pkg::PIXEL_HI - gsc_pkg::PIN_LO:0];
		video_pixel_pins_oe     = pin_oe[gsc_pkg::PIXEL_HI - gsc_pkg::PIN_LO:0];
	end

endmodule : gsc_alias_top

/* File: gsc_alias_top_chk.sv */
// Checker with the bus and pin assertions of the set and clear alias block.
`timescale 1ns/1ns
module gsc_alias_top_chk #(
	parameter int unsigned AW = gsc_pkg::ADDR_W
) (
	// Clock, reset and bus.
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [AW-1:0] paddr,
	input  wire logic [31:0]   pwdata,
	input  wire logic [3:0]    pstrb,
	input  wire logic [31:0]   prdata,
	input  wire logic          pready,
	// Pins.
	input  wire logic          video_ctrl_pin_three,
	input  wire logic [19:2]   video_pixel_pins
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_set;
	logic wr_clr;
	logic rd_set;
	logic rd_clr;
	assign wr_set = pready && pwrite && paddr == gsc_pkg::OFF_SET;
	assign wr_clr = pready && pwrite && paddr == gsc_pkg::OFF_CLEAR;
	assign rd_set = pready && !pwrite && paddr == gsc_pkg::OFF_SET;
	assign rd_clr = pready && !pwrite && paddr == gsc_pkg::OFF_CLEAR;
	rdy_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	rdy_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	set_read_a: assert property (rd_set |-> prdata == 32'h0000_0000)
		else $error("set alias read not zero");
	clr_read_a: assert property (rd_clr |-> prdata == 32'h0000_0000)
		else $error("clear alias read not zero");
	rsvd_read_a: assert property (pready && !pwrite |-> prdata[31:23] == 9'h000)
		else $error("reserved bits read not zero");
	set_ctrl_a: assert property (wr_set && pwdata[22] && pstrb[2] |-> ##2 video_ctrl_pin_three)
		else $error("control pin not set");
	clr_ctrl_a: assert property (wr_clr && pwdata[22] && pstrb[2] |-> ##2 !video_ctrl_pin_three)
		else $error("control pin not cleared");
	set_pixel_a: assert property (wr_set && pwdata[19] && pstrb[2] |-> ##2 video_pixel_pins[19])
		else $error("pixel pin not set");
	keep_pixel_a: assert property ((wr_set || wr_clr) && !pwdata[5]
		|-> ##2 $stable(video_pixel_pins[5]))
		else $error("pixel pin changed by zero bit");
	cover property (wr_set);
	cover property (wr_clr);
	cover property (rd_set || rd_clr);
endmodule : gsc_alias_top_chk

bind gsc_alias_top gsc_alias_top_chk #(.AW(AW)) gsc_alias_top_chk_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.video_ctrl_pin_three(video_ctrl_pin_three), .video_pixel_pins(video_pixel_pins));

/* File: gsc_alias_top_tb.sv */
// Testbench for the pin output value register and its set and clear aliases.
`timescale 1ns/1ns
module gsc_alias_top_tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        c1, c2, c3, c1_oe, c2_oe, c3_oe, c1_in, c2_in, c3_in;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, d, exp_val, exp_dir, m, lv;
	logic [3:0]  pstrb, s;
	logic [19:2] pix, pix_oe, pix_in;
	logic [11:0] offs [4];
	int          miscompares, num_checks, op;

	gsc_alias_top gsc_alias_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .video_ctrl_pin_one(c1),
		.video_ctrl_pin_one_oe(c1_oe), .video_ctrl_pin_one_in(c1_in), .video_ctrl_pin_two(c2),
		.video_ctrl_pin_two_oe(c2_oe), .video_ctrl_pin_two_in(c2_in),
		.video_ctrl_pin_three(c3), .video_ctrl_pin_three_oe(c3_oe),
		.video_ctrl_pin_three_in(c3_in), .video_pixel_pins(pix),
		.video_pixel_pins_oe(pix_oe), .video_pixel_pins_in(pix_in));

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic end_of_test;
		$display("Checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		repeat (3000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{c1_in, c2_in, c3_in, pix_in} = '0;
		pstrb = 4'hF;
		presetn = 1'b0;
		exp_val = 32'h0000_0000;
		exp_dir = 32'h0000_0000;
		offs = '{gsc_pkg::OFF_VALUE, gsc_pkg::OFF_SET, gsc_pkg::OFF_CLEAR, gsc_pkg::OFF_DIR};
		void'($urandom(32'hB0A3));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, gsc_pkg::OFF_VALUE, 32'h0000_0000);
		chk("reset value", 32'h0000_0000, rd);
		for (int i = 0; i < 40; i++) begin
			op = $urandom_range(3, 0);
			d = $urandom();
			s = 4'($urandom());
			pstrb <= s;
			m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & gsc_pkg::PIN_MASK;
			{c1_in, c2_in, c3_in, pix_in} <= 21'($urandom());
			if (op == 0) exp_val = (exp_val & ~m) | (d & m);
			else if (op == 1) exp_val = exp_val | (d & m);
			else if (op == 2) exp_val = exp_val & ~(d & m);
			else exp_dir = (exp_dir & ~m) | (d & m);
			apb(1'b1, offs[op], d);
			apb(1'b0, offs[1 + i % 2], 32'h0000_0000);
			chk("alias read", 32'h0000_0000, rd);
			apb(1'b0, gsc_pkg::OFF_VALUE, 32'h0000_0000);
			chk("value", exp_val, rd);
			chk("pins", exp_val, {9'h000, c3, c2, c1, pix, 2'h0});
			chk("enables", exp_dir, {9'h000, c3_oe, c2_oe, c1_oe, pix_oe, 2'h0});
			apb(1'b0, gsc_pkg::OFF_DIR, 32'h0000_0000);
			chk("direction", exp_dir, rd);
			lv = {9'h000, c3_in, c2_in, c1_in, pix_in, 2'h0};
			apb(1'b0, gsc_pkg::OFF_LEVEL, 32'h0000_0000);
			chk("level", lv, rd);
		end
		apb(1'b0, 12'hFF0, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, err});
		chk("unmapped read", 32'h0000_0000, rd);
		end_of_test();
	end
endmodule : gsc_alias_top_tb

/* File: gsc_pin_drive.sv */
// Pin stage: registered pin drive and enable, and a two-stage synchroniser for pin levels.
`timescale 1ns/1ns
module gsc_pin_drive #(
	parameter int unsigned WIDTH = 21
) (
	// Clock and reset.
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Register side.
	input  wire logic [WIDTH-1:0] value,
	input  wire logic [WIDTH-1:0] dir_out,
	output logic      [WIDTH-1:0] level,
	// Pin side.
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe,
	input  wire logic [WIDTH-1:0] pin_in
);

	logic [WIDTH-1:0] sync_first;
	logic [WIDTH-1:0] next_pin_out;
	logic [WIDTH-1:0] next_pin_oe;

	// The stored value is always presented; the enable alone decides whether it is driven.
	always_comb begin
		next_pin_out = value;
		next_pin_oe  = dir_out;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out    <= '0;
			pin_oe     <= '0;
			sync_first <= '0;
			level      <= '0;
		end else begin
			pin_out    <= next_pin_out;
			pin_oe     <= next_pin_oe;
			sync_first <= pin_in;
			level      <= sync_first;
		end
	end

endmodule : gsc_pin_drive

/* File: gsc_pkg.sv */
// Package with register map, field layout and bus states of the GPIO set/clear alias block.
package gsc_pkg;

	// Register byte offsets on the APB.
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFF_VALUE = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_SET   = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_CLEAR = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_DIR   = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_LEVEL = 12'h010;

	// Field layout of the pin word.
	localparam int unsigned PIN_LO       = 2;
	localparam int unsigned PIN_HI       = 22;
	localparam int unsigned PIN_W        = PIN_HI - PIN_LO + 1;
	localparam int unsigned PIXEL_HI     = 19;
	localparam int unsigned CTRL_ONE     = 20;
	localparam int unsigned CTRL_TWO     = 21;
	localparam int unsigned CTRL_THREE   = 22;
	localparam logic [31:0] PIN_MASK     = 32'h007F_FFFC;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
	localparam logic [PIN_W-1:0] PIN_RST = 21'h00_0000;

	// Slave phase.
	typedef enum logic [0:0] {
		GSC_IDLE   = 1'b0,
		GSC_ACCESS = 1'b1
	} gsc_phase_e;

endpackage : gsc_pkg
